// File: nv_pkg.sv
// constants shared by both ends of the data eeprom access path
// assumes one system clock and an active-low synchronous reset
package nv_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned PTR_W = 8;
    // control register reached indirectly at sector 1, offset 040h
    localparam logic [PTR_W-1:0] CTRL_PTR_LOW = 8'h40;
    localparam logic [PTR_W-1:0] CTRL_PTR_HIGH = 8'h01;
    localparam logic [PTR_W-1:0] PTR_HIGH_SAFE = 8'h00;
    // control register fields
    localparam int unsigned BIT_WR_EN = 3;
    localparam int unsigned BIT_WR_GO = 2;
    localparam int unsigned BIT_RD_EN = 1;
    localparam int unsigned BIT_RD_GO = 0;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] CTRL_IMPL_MASK = 8'h0f;
    // write cycle timing in timer ticks; one tick per TICK_DIV system clocks
    localparam int unsigned WRITE_TICKS = 16;
    localparam int unsigned TICK_DIV = 4;
    localparam int unsigned READ_CYCLES = 2;
    localparam int unsigned MEM_DEPTH = 256;
    // register select codes on the special register bus
    localparam logic [1:0] SEL_ADDR = 2'h0;
    localparam logic [1:0] SEL_DATA = 2'h1;
    localparam logic [1:0] SEL_PTR_LOW = 2'h2;
    localparam logic [1:0] SEL_PTR_HIGH = 2'h3;
endpackage

// File: nv_sfr_if.sv
// special register bus between cpu side and eeprom sequencer
// assumes both ends clocked by the same clk_sys_i
`timescale 1ns/1ns
interface nv_sfr_if;
    logic dir_wr;
    logic [1:0] dir_sel;
    logic ind_wr;
    logic [nv_pkg::DATA_W-1:0] wdata;
    logic [nv_pkg::DATA_W-1:0] addr_rd;
    logic [nv_pkg::DATA_W-1:0] data_rd;
    logic [nv_pkg::DATA_W-1:0] ind_rd;
    logic [nv_pkg::PTR_W-1:0] ptr_high_rd;
    logic write_done_flag;
    logic write_done_clr;
    logic mf_req;
    logic mf_clr;
    logic sleep_req;
    logic busy;
    modport device (
        input dir_wr, dir_sel, ind_wr, wdata, write_done_clr, mf_clr, sleep_req,
        output addr_rd, data_rd, ind_rd, ptr_high_rd, write_done_flag, mf_req, busy
    );
    modport host (
        output dir_wr, dir_sel, ind_wr, wdata, write_done_clr, mf_clr, sleep_req,
        input addr_rd, data_rd, ind_rd, ptr_high_rd, write_done_flag, mf_req, busy
    );
endinterface

// File: data_eeprom_access_sequencer.sv
// eeprom access sequencer: address, data, pointer and indirect control reg
// assumes the cpu end drives at most one direct and one indirect register access per cycle
// What this block and the cpu end do
// - software sets write-start right after write-enable
// - software masks interrupts around write start
// - no sleep until operation finished
// - software keeps write-enable low normally
// - pointer high zero hides control register
// - software may read back written data
// - control register at pointer 040h/01h
// - read: address, enable, start, poll, take
// - write: address, data, enable, start, poll
// - cleared control register disables everything
// - start bit ignored without its enable
// - start bits self-clear; read data held
// - control bits 3..0, upper read zero
// - write end sets done and multi-function flags
`timescale 1ns/1ns
module data_eeprom_access_sequencer #(
    parameter int unsigned WRITE_TICKS = nv_pkg::WRITE_TICKS,
    parameter int unsigned TICK_DIV = nv_pkg::TICK_DIV
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // cpu register bus
    nv_sfr_if.device bus,
    // status seen by the rest of the chip
    output logic busy_o,
    output logic op_failed_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_READ = 3'b010,
        ST_WRITE = 3'b100
    } state_t;

    state_t state_q;
    logic [nv_pkg::DATA_W-1:0] mem_q [nv_pkg::MEM_DEPTH];
    logic [nv_pkg::ADDR_W-1:0] addr_q;
    logic [nv_pkg::DATA_W-1:0] data_q;
    logic [nv_pkg::PTR_W-1:0] ptr_low_q;
    logic [nv_pkg::PTR_W-1:0] ptr_high_q;
    logic wr_en_q, wr_go_q, rd_en_q, rd_go_q;
    logic done_q, mf_q, fail_q;
    logic [15:0] tick_div_q;
    logic [15:0] cnt_q;
    logic tick;
    logic ctrl_sel;
    logic ctrl_wr;
    logic start_rd, start_wr, finish_rd, finish_wr;

    assign ctrl_sel = (ptr_low_q == nv_pkg::CTRL_PTR_LOW)
                   && (ptr_high_q == nv_pkg::CTRL_PTR_HIGH);
    // control register writes during an operation are ignored so the running cycle is undisturbed
    assign ctrl_wr = bus.ind_wr && ctrl_sel && (state_q == ST_IDLE);
    // enable must already be stored: go written together with a fresh enable is refused
    assign start_rd = ctrl_wr && rd_en_q && bus.wdata[nv_pkg::BIT_RD_EN]
                   && bus.wdata[nv_pkg::BIT_RD_GO] && !bus.wdata[nv_pkg::BIT_WR_GO];
    assign start_wr = ctrl_wr && wr_en_q && bus.wdata[nv_pkg::BIT_WR_EN]
                   && bus.wdata[nv_pkg::BIT_WR_GO] && !bus.wdata[nv_pkg::BIT_RD_GO];
    assign tick = (tick_div_q == 16'(TICK_DIV - 1));
    assign finish_rd = (state_q == ST_READ) && (cnt_q == 16'(nv_pkg::READ_CYCLES - 1));
    assign finish_wr = (state_q == ST_WRITE) && tick && (cnt_q == 16'(WRITE_TICKS - 1));

    // internal write timer divider, free running
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || tick)
            tick_div_q <= 16'h0000;
        else
            tick_div_q <= tick_div_q + 16'h0001;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    cnt_q <= 16'h0000;
                    if (start_rd)
                        state_q <= ST_READ;
                    else if (start_wr)
                        state_q <= ST_WRITE;
                end
                ST_READ:
                begin
                    cnt_q <= cnt_q + 16'h0001;
                    if (finish_rd || bus.sleep_req)
                        state_q <= ST_IDLE;
                end
                ST_WRITE:
                begin
                    if (tick)
                        cnt_q <= cnt_q + 16'h0001;
                    if (finish_wr || bus.sleep_req)
                        state_q <= ST_IDLE;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // pointer and direct registers
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            ptr_low_q <= nv_pkg::PTR_HIGH_SAFE;
            ptr_high_q <= nv_pkg::PTR_HIGH_SAFE;
        end
        else if (bus.dir_wr && bus.dir_sel == nv_pkg::SEL_PTR_LOW)
            ptr_low_q <= bus.wdata;
        else if (bus.dir_wr && bus.dir_sel == nv_pkg::SEL_PTR_HIGH)
            ptr_high_q <= bus.wdata;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            addr_q <= '0;
        else if (bus.dir_wr && bus.dir_sel == nv_pkg::SEL_ADDR && state_q == ST_IDLE)
            addr_q <= bus.wdata;
    end

    // read data held until the next read or a direct data register write replaces it
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            data_q <= '0;
        else if (finish_rd && !bus.sleep_req)
            data_q <= mem_q[addr_q];
        else if (bus.dir_wr && bus.dir_sel == nv_pkg::SEL_DATA && state_q == ST_IDLE)
            data_q <= bus.wdata;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (finish_wr && !bus.sleep_req)
            mem_q[addr_q] <= data_q;
    end

    // control register
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            wr_en_q <= 1'b0;
            rd_en_q <= 1'b0;
            wr_go_q <= 1'b0;
            rd_go_q <= 1'b0;
        end
        else if (ctrl_wr)
        begin
            wr_en_q <= bus.wdata[nv_pkg::BIT_WR_EN];
            rd_en_q <= bus.wdata[nv_pkg::BIT_RD_EN];
            wr_go_q <= start_wr;
            rd_go_q <= start_rd;
        end
        else
        begin
            if (finish_rd || (state_q == ST_READ && bus.sleep_req))
                rd_go_q <= 1'b0;
            if (finish_wr || (state_q == ST_WRITE && bus.sleep_req))
                wr_go_q <= 1'b0;
        end
    end

    // done flags: set wins over software clear
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            done_q <= 1'b0;
            mf_q <= 1'b0;
        end
        else
        begin
            if (finish_wr)
                done_q <= 1'b1;
            else if (bus.write_done_clr)
                done_q <= 1'b0;
            if (finish_wr)
                mf_q <= 1'b1;
            else if (bus.mf_clr)
                mf_q <= 1'b0;
        end
    end

    // sleep during an operation spoils it
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            fail_q <= 1'b0;
        else if (state_q != ST_IDLE && bus.sleep_req)
            fail_q <= 1'b1;
        else if (start_rd || start_wr)
            fail_q <= 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
            busy_o <= 1'b0;
        else
            busy_o <= (state_q != ST_IDLE) && !(finish_rd || finish_wr);
    end

    assign op_failed_o = fail_q;
    assign bus.busy = busy_o;
    assign bus.addr_rd = addr_q;
    assign bus.data_rd = data_q;
    assign bus.ptr_high_rd = ptr_high_q;
    assign bus.ind_rd = ctrl_sel ? ({4'h0, wr_en_q, wr_go_q, rd_en_q, rd_go_q}
                                    & nv_pkg::CTRL_IMPL_MASK) : '0;
    assign bus.write_done_flag = done_q;
    assign bus.mf_req = mf_q;
endmodule

// File: nv_cpu_end.sv
// cpu end: runs the documented read and write sequences on request
// assumes the sequencer end on the same interface and clock
`timescale 1ns/1ns
module nv_cpu_end (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // register bus
    nv_sfr_if.host bus,
    // user requests
    input wire logic rd_req_i,
    input wire logic wr_req_i,
    input wire logic [nv_pkg::ADDR_W-1:0] addr_i,
    input wire logic [nv_pkg::DATA_W-1:0] wdata_i,
    input wire logic sleep_i,
    // user answers
    output logic done_o,
    output logic [nv_pkg::DATA_W-1:0] rdata_o,
    output logic irq_en_o,
    output logic sleep_ok_o
);
    typedef enum logic [8:0] {
        S_IDLE = 9'b000000001,
        S_ADDR = 9'b000000010,
        S_DATA = 9'b000000100,
        S_PLOW = 9'b000001000,
        S_PHIGH = 9'b000010000,
        S_EN = 9'b000100000,
        S_GO = 9'b001000000,
        S_POLL = 9'b010000000,
        S_CLEAN = 9'b100000000
    } state_t;

    state_t state_q;
    logic is_wr_q;
    logic [nv_pkg::ADDR_W-1:0] addr_q;
    logic [nv_pkg::DATA_W-1:0] data_q;
    logic [nv_pkg::DATA_W-1:0] ctrl_v;

    always_comb
    begin
        ctrl_v = '0;
        if (is_wr_q)
        begin
            ctrl_v[nv_pkg::BIT_WR_EN] = 1'b1;
            ctrl_v[nv_pkg::BIT_WR_GO] = (state_q == S_GO);
        end
        else
        begin
            ctrl_v[nv_pkg::BIT_RD_EN] = 1'b1;
            ctrl_v[nv_pkg::BIT_RD_GO] = (state_q == S_GO);
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            state_q <= S_IDLE;
            is_wr_q <= 1'b0;
            addr_q <= '0;
            data_q <= '0;
        end
        else
        begin
            case (state_q)
                S_IDLE:
                    if (wr_req_i || rd_req_i)
                    begin
                        is_wr_q <= wr_req_i;
                        addr_q <= addr_i;
                        data_q <= wdata_i;
                        state_q <= S_ADDR;
                    end
                S_ADDR: state_q <= is_wr_q ? S_DATA : S_PLOW;
                S_DATA: state_q <= S_PLOW;
                S_PLOW: state_q <= S_PHIGH;
                S_PHIGH: state_q <= S_EN;
                S_EN: state_q <= S_GO;
                S_GO: state_q <= S_POLL;
                S_POLL:
                    if (!bus.busy && bus.ind_rd[is_wr_q ? nv_pkg::BIT_WR_GO
                                                        : nv_pkg::BIT_RD_GO] == 1'b0)
                        state_q <= S_CLEAN;
                S_CLEAN: state_q <= S_IDLE;
                default: state_q <= S_IDLE;
            endcase
        end
    end

    always_comb
    begin
        bus.dir_wr = 1'b0;
        bus.dir_sel = nv_pkg::SEL_ADDR;
        bus.ind_wr = 1'b0;
        bus.wdata = '0;
        case (state_q)
            S_ADDR:
            begin
                bus.dir_wr = 1'b1;
                bus.wdata = addr_q;
            end
            S_DATA:
            begin
                bus.dir_wr = 1'b1;
                bus.dir_sel = nv_pkg::SEL_DATA;
                bus.wdata = data_q;
            end
            S_PLOW:
            begin
                bus.dir_wr = 1'b1;
                bus.dir_sel = nv_pkg::SEL_PTR_LOW;
                bus.wdata = nv_pkg::CTRL_PTR_LOW;
            end
            S_PHIGH:
            begin
                bus.dir_wr = 1'b1;
                bus.dir_sel = nv_pkg::SEL_PTR_HIGH;
                bus.wdata = nv_pkg::CTRL_PTR_HIGH;
            end
            S_EN, S_GO:
            begin
                bus.ind_wr = 1'b1;
                bus.wdata = ctrl_v;
            end
            S_CLEAN:
            begin
                // one cycle clears both: pointer still selects control reg at this edge,
                // and the safe pointer value is also the cleared control value
                bus.ind_wr = 1'b1;
                bus.dir_wr = 1'b1;
                bus.dir_sel = nv_pkg::SEL_PTR_HIGH;
                bus.wdata = nv_pkg::PTR_HIGH_SAFE;
            end
            default:
            begin
                bus.dir_wr = 1'b0;
            end
        endcase
    end

    assign bus.write_done_clr = (state_q == S_CLEAN) && is_wr_q;
    assign bus.mf_clr = (state_q == S_CLEAN) && is_wr_q;
    assign bus.sleep_req = sleep_i && (state_q == S_IDLE);

    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i)
        begin
            done_o <= 1'b0;
            rdata_o <= '0;
            irq_en_o <= 1'b1;
            sleep_ok_o <= 1'b1;
        end
        else
        begin
            done_o <= (state_q == S_CLEAN);
            if (state_q == S_CLEAN && !is_wr_q)
                rdata_o <= bus.data_rd;
            irq_en_o <= !(is_wr_q && (state_q == S_EN || state_q == S_PHIGH));
            sleep_ok_o <= (state_q == S_IDLE) && !bus.busy;
        end
    end
endmodule

// File: nv_access_monitor.sv
// bus checker for the cpu end and the eeprom sequencer
// assumes the interface signals are wired in by name, one clock
`timescale 1ns/1ns
module nv_access_monitor #(
    parameter int unsigned WRITE_TICKS = nv_pkg::WRITE_TICKS,
    parameter int unsigned TICK_DIV = nv_pkg::TICK_DIV
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic nrst_i,
    // watched bus
    input wire logic dir_wr,
    input wire logic [1:0] dir_sel,
    input wire logic ind_wr,
    input wire logic [nv_pkg::DATA_W-1:0] wdata,
    input wire logic [nv_pkg::DATA_W-1:0] data_rd,
    input wire logic [nv_pkg::DATA_W-1:0] ind_rd,
    input wire logic [nv_pkg::PTR_W-1:0] ptr_high_rd,
    input wire logic write_done_flag,
    input wire logic mf_req,
    input wire logic busy
);
    // span limits leave room for the free-running tick phase
    localparam int WR_LO = (WRITE_TICKS - 1) * TICK_DIV;
    localparam int WR_HI = (WRITE_TICKS + 1) * TICK_DIV + 2;
    logic wr_go;
    logic wr_end;
    logic data_wr;
    logic wr_run_q;
    logic [15:0] wr_cnt_q;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!nrst_i);
    assign wr_go = ind_wr && !busy && ind_rd[nv_pkg::BIT_WR_EN] && wdata[3:0] == 4'hc;
    assign wr_end = wr_run_q && !busy && wr_cnt_q != 16'h0000;
    assign data_wr = dir_wr && dir_sel == nv_pkg::SEL_DATA;
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || wr_end)
            wr_run_q <= 1'b0;
        else if (wr_go)
            wr_run_q <= 1'b1;
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (!nrst_i || wr_go)
            wr_cnt_q <= 16'h0000;
        else if (wr_run_q && busy)
            wr_cnt_q <= wr_cnt_q + 16'h0001;
    end
    sequence seq_rd_go;
        ind_wr && !busy && ind_rd[nv_pkg::BIT_RD_EN] && wdata[3:0] == 4'h3;
    endsequence
    sequence seq_busy_pulse;
        ##[1:2] busy ##[1:8] !busy;
    endsequence
    chk_go_after_en: assert property (
        ind_wr && wdata[3:0] == 4'h8 |=> ind_wr && wdata[3:0] == 4'hc)
        else $error("write start did not follow write enable");
    chk_wr_begin: assert property (wr_go |-> ##[1:2] busy)
        else $error("write did not start");
    chk_rd_span: assert property (seq_rd_go |-> seq_busy_pulse)
        else $error("read cycle missing or too long");
    chk_wr_span: assert property (
        wr_end |-> wr_cnt_q >= WR_LO && wr_cnt_q <= WR_HI)
        else $error("write cycle length out of range");
    chk_done_flags: assert property (
        wr_end |-> ##[0:1] (write_done_flag && mf_req))
        else $error("write end flags not set");
    chk_start_clears: assert property (
        $fell(busy) |-> ind_rd[nv_pkg::BIT_RD_GO] == 1'b0 && ind_rd[nv_pkg::BIT_WR_GO] == 1'b0)
        else $error("start bit still set after operation");
    chk_hidden_ctrl: assert property (
        ptr_high_rd != nv_pkg::CTRL_PTR_HIGH |-> ind_rd == 8'h00)
        else $error("control register visible in wrong sector");
    chk_upper_zero: assert property (ind_rd[7:4] == 4'h0)
        else $error("unused control bits not zero");
    chk_data_held: assert property (
        $changed(data_rd) |-> $past(busy) || $past(data_wr))
        else $error("data register changed without operation");
    chk_ctrl_left_clear: assert property (
        ind_wr && (wdata[3:0] == 4'h8 || wdata[3:0] == 4'h2) |-> ind_rd[3:0] == 4'h0)
        else $error("control register not cleared after last operation");
endmodule

// File: data_eeprom_access_sequencer_test.sv
// bench: cpu end joined to a sequencer, and a second sequencer driven by hand
// assumes package, interface and design ends compiled first
`timescale 1ns/1ns
module data_eeprom_access_sequencer_test;
    localparam int unsigned WT = 3;
    localparam int unsigned TD = 2;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data;} row_t;
    localparam row_t rows [6] = '{'{1'b1, 8'h00, 8'h5a}, '{1'b1, 8'hff, 8'ha5},
        '{1'b0, 8'h00, 8'h5a}, '{1'b0, 8'hff, 8'ha5}, '{1'b1, 8'h00, 8'hc3}, '{1'b0, 8'h00, 8'hc3}};
    logic clk_sys_i = 1'b0;
    logic nrst_i = 1'b0;
    logic rd_req, wr_req, sleep, done, irq_en, sleep_ok, busy_b, failed_b;
    logic [7:0] addr, wdata, rdata;
    int err_count = 0;
    int checked = 0;
    nv_sfr_if i_nv_sfr_if();
    nv_sfr_if i_nv_sfr_if_b();
    data_eeprom_access_sequencer #(.WRITE_TICKS(WT), .TICK_DIV(TD)) i_data_eeprom_access_sequencer (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus(i_nv_sfr_if), .busy_o(), .op_failed_o());
    data_eeprom_access_sequencer #(.WRITE_TICKS(WT), .TICK_DIV(TD)) i_data_eeprom_access_sequencer_b (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus(i_nv_sfr_if_b), .busy_o(busy_b),
        .op_failed_o(failed_b));
    nv_cpu_end i_nv_cpu_end (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .bus(i_nv_sfr_if),
        .rd_req_i(rd_req), .wr_req_i(wr_req), .addr_i(addr), .wdata_i(wdata), .sleep_i(sleep),
        .done_o(done), .rdata_o(rdata), .irq_en_o(irq_en), .sleep_ok_o(sleep_ok));
    nv_access_monitor #(.WRITE_TICKS(WT), .TICK_DIV(TD)) i_nv_access_monitor (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .dir_wr(i_nv_sfr_if.dir_wr),
        .dir_sel(i_nv_sfr_if.dir_sel), .ind_wr(i_nv_sfr_if.ind_wr), .wdata(i_nv_sfr_if.wdata),
        .data_rd(i_nv_sfr_if.data_rd), .ind_rd(i_nv_sfr_if.ind_rd),
        .ptr_high_rd(i_nv_sfr_if.ptr_high_rd), .write_done_flag(i_nv_sfr_if.write_done_flag),
        .mf_req(i_nv_sfr_if.mf_req), .busy(i_nv_sfr_if.busy));
    always #50 clk_sys_i = ~clk_sys_i;
    task automatic stop_test();
        if (err_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            err_count++;
        end
    endtask
    task automatic expire(input logic ok);
        if (!ok)
        begin
            err_count++;
            stop_test();
        end
    endtask
    task automatic do_reset();
        nrst_i = 1'b0;
        repeat (5) @(negedge clk_sys_i);
        nrst_i = 1'b1;
        @(negedge clk_sys_i);
        compare({2'b00, busy_b, failed_b, i_nv_sfr_if_b.write_done_flag, i_nv_sfr_if_b.mf_req,
            irq_en, sleep_ok}, 8'h03);
        compare(i_nv_sfr_if_b.ptr_high_rd, 8'h00);
    endtask
    // cpu end sequence; sleep pulsed mid-run must not reach the sequencer
    task automatic run_op(input row_t r);
        logic irq_low;
        logic awake;
        irq_low = 1'b0;
        awake = 1'b0;
        @(negedge clk_sys_i);
        wr_req = r.wr;
        rd_req = !r.wr;
        addr = r.addr;
        wdata = r.data;
        @(negedge clk_sys_i);
        wr_req = 1'b0;
        rd_req = 1'b0;
        for (int n = 0; n < 300 && done !== 1'b1; n++)
        begin
            irq_low |= !irq_en;
            if (n > 0)
                awake |= sleep_ok | i_nv_sfr_if.sleep_req;
            sleep = (n == 3);
            @(negedge clk_sys_i);
        end
        expire(done === 1'b1);
        compare({7'h00, awake}, 8'h00);
        compare(i_nv_sfr_if.ptr_high_rd, 8'h00);
        if (r.wr)
        begin
            compare({7'h00, irq_low}, 8'h01);
            compare({7'h00, i_nv_sfr_if.write_done_flag}, 8'h00);
        end
        else
            compare(rdata, r.data);
    endtask
    // second sequencer: sets strobes now, b_rel drops them a cycle later
    task automatic b_wr(input logic ind, input logic [1:0] sel, input logic [7:0] d);
        @(negedge clk_sys_i);
        i_nv_sfr_if_b.dir_wr = !ind;
        i_nv_sfr_if_b.ind_wr = ind;
        i_nv_sfr_if_b.dir_sel = sel;
        i_nv_sfr_if_b.wdata = d;
    endtask
    task automatic b_rel();
        @(negedge clk_sys_i);
        i_nv_sfr_if_b.dir_wr = 1'b0;
        i_nv_sfr_if_b.ind_wr = 1'b0;
        i_nv_sfr_if_b.write_done_clr = 1'b0;
        i_nv_sfr_if_b.sleep_req = 1'b0;
    endtask
    task automatic b_idle();
        for (int n = 0; n < 100 && busy_b !== 1'b0; n++)
            @(negedge clk_sys_i);
        expire(busy_b === 1'b0);
    endtask
    initial
    begin
        {rd_req, wr_req, sleep} = 3'b000;
        addr = 8'h00;
        wdata = 8'h00;
        {i_nv_sfr_if_b.dir_wr, i_nv_sfr_if_b.ind_wr, i_nv_sfr_if_b.dir_sel} = 4'h0;
        {i_nv_sfr_if_b.write_done_clr, i_nv_sfr_if_b.mf_clr, i_nv_sfr_if_b.sleep_req} = 3'b000;
        i_nv_sfr_if_b.wdata = 8'h00;
        do_reset();
        foreach (rows[i])
            run_op(rows[i]);
        @(negedge clk_sys_i);
        sleep = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        compare({7'h00, i_nv_sfr_if.sleep_req}, 8'h01);
        sleep = 1'b0;
        b_wr(1'b0, nv_pkg::SEL_PTR_LOW, 8'h40);
        b_wr(1'b1, 2'h0, 8'h0a);
        b_wr(1'b0, nv_pkg::SEL_PTR_HIGH, 8'h01);
        b_rel();
        compare(i_nv_sfr_if_b.ind_rd, 8'h00);
        b_wr(1'b1, 2'h0, 8'hfa);
        b_rel();
        compare(i_nv_sfr_if_b.ind_rd, 8'h0a);
        b_wr(1'b1, 2'h0, 8'h00);
        b_rel();
        compare(i_nv_sfr_if_b.ind_rd, 8'h00);
        b_wr(1'b1, 2'h0, 8'h01);
        b_wr(1'b1, 2'h0, 8'h04);
        b_wr(1'b1, 2'h0, 8'h0c);
        b_rel();
        repeat (2) @(negedge clk_sys_i);
        compare({7'h00, busy_b}, 8'h00);
        compare(i_nv_sfr_if_b.ind_rd, 8'h08);
        b_wr(1'b0, nv_pkg::SEL_ADDR, 8'h07);
        b_wr(1'b0, nv_pkg::SEL_DATA, 8'h99);
        b_wr(1'b1, 2'h0, 8'h08);
        b_wr(1'b1, 2'h0, 8'h0c);
        b_rel();
        @(negedge clk_sys_i);
        compare({7'h00, busy_b}, 8'h01);
        b_wr(1'b1, 2'h0, 8'h00);
        b_rel();
        compare(i_nv_sfr_if_b.ind_rd, 8'h0c);
        b_idle();
        compare(i_nv_sfr_if_b.ind_rd, 8'h08);
        compare({6'h00, i_nv_sfr_if_b.write_done_flag, i_nv_sfr_if_b.mf_req}, 8'h03);
        @(negedge clk_sys_i);
        i_nv_sfr_if_b.write_done_clr = 1'b1;
        b_rel();
        compare({6'h00, i_nv_sfr_if_b.write_done_flag, i_nv_sfr_if_b.mf_req}, 8'h01);
        b_wr(1'b1, 2'h0, 8'h0c);
        b_rel();
        @(negedge clk_sys_i);
        i_nv_sfr_if_b.sleep_req = 1'b1;
        b_rel();
        @(negedge clk_sys_i);
        compare({7'h00, failed_b}, 8'h01);
        b_idle();
        do_reset();
        stop_test();
    end
endmodule
